// *** rtl/rx_comm_pkg.sv ***
// package: constants, types and codes for the receiver communication block
`default_nettype none
package rx_comm_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned BIT_PERIOD_US = 500;
	localparam int unsigned BIT_CYCLES    = CLK_HZ / 1_000_000 * BIT_PERIOD_US;
	localparam int unsigned HALF_CYCLES   = BIT_CYCLES / 2;
	localparam int unsigned FRAME_BITS    = 11;
	localparam int unsigned DATA_BITS     = 8;
	localparam int unsigned MAX_BYTES     = 4;

	// ----------------------------------------------------------------
	// current limit figures, in mA
	// ----------------------------------------------------------------
	localparam logic [11:0] ILIM_SWITCH_MA = 12'd300;
	localparam logic [11:0] ILIM_FIXED_MA  = 12'd400;
	localparam logic [11:0] ILIM_MARGIN_MA = 12'd50;
	localparam logic [11:0] ILIM_NONE_MA   = 12'hFFF;

	// ----------------------------------------------------------------
	// packet codes
	// ----------------------------------------------------------------
	localparam logic [7:0] HDR_END_POWER  = 8'h02;
	localparam logic [7:0] REASON_UNKNOWN = 8'h00;
	localparam logic [7:0] REASON_FAULT   = 8'h02;
	localparam logic [7:0] REASON_OVERTMP = 8'h03;

	// ----------------------------------------------------------------
	// register map (AHB-Lite, word aligned)
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_DATA0  = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_ILIM   = 8'h0C;
	localparam int unsigned CTRL_GO   = 0;
	localparam int unsigned CTRL_LEN  = 4;
	localparam int unsigned AW        = 8;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {RECT_DIODE, RECT_HALF, RECT_FULL} rect_mode_t;
	typedef struct packed {
		logic uvlo_ok;
		logic above_full_sync;
		logic below_half_return;
		logic die_hot;
		logic die_cool;
	} analog_flags_t;
	typedef struct packed {
		logic       busy;
		logic       shutdown;
		logic [7:0] last_reason;
	} status_t;
endpackage
`default_nettype wire

// *** rtl/bit_serializer.sv ***
// module: one framed byte to bi-phase modulation transitions
`default_nettype none
module bit_serializer
	import rx_comm_pkg::*;
(
	// clock and reset
	input  wire logic       hclk,
	input  wire logic       hresetn,
	// byte handshake
	input  wire logic       start,
	input  wire logic [7:0] data,
	output logic            busy,
	output logic            done,
	// modulation level
	output logic            mod_level
);
	localparam int unsigned CW = $clog2(BIT_CYCLES);
	logic [CW-1:0]   cyc_q;    // cycle within bit
	logic [3:0]      bit_q;    // bit within frame
	logic [10:0]     frame_q;  // framed shift word
	logic            active_q;

	// odd parity over the data byte
	function automatic logic odd_par(input logic [7:0] b);
		odd_par = ~(^b);
	endfunction

	// ----------------------------------------------------------------
	// bit timing and frame shift
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cyc_q    <= '0;
			bit_q    <= '0;
			frame_q  <= '0;
			active_q <= 1'b0;
			done     <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!active_q) begin
				if (start) begin
					// start 0, data lsb first, parity, stop 1
					frame_q  <= {1'b1, odd_par(data), data, 1'b0};
					active_q <= 1'b1;
					cyc_q    <= '0;
					bit_q    <= '0;
				end
			end else if (cyc_q == CW'(BIT_CYCLES - 1)) begin
				cyc_q   <= '0;
				frame_q <= {1'b0, frame_q[10:1]};
				if (bit_q == 4'(FRAME_BITS - 1)) begin
					active_q <= 1'b0;
					done     <= 1'b1;
				end else begin
					bit_q <= bit_q + 4'd1;
				end
			end else begin
				cyc_q <= cyc_q + CW'(1);
			end
		end
	end

	// ----------------------------------------------------------------
	// differential bi-phase: flip at each boundary, again mid-bit for one
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mod_level <= 1'b0;
		end else if (active_q && cyc_q == '0) begin
			mod_level <= ~mod_level;
		end else if (active_q && cyc_q == CW'(HALF_CYCLES) && frame_q[0]) begin
			mod_level <= ~mod_level;
		end else if (!active_q && !start && !done) begin // cleared when idle, held across byte gap
			mod_level <= 1'b0;
		end
	end

	assign busy = active_q;
endmodule
`default_nettype wire

// *** rtl/rx_comm_ctrl.sv ***
// module: receiver communication, current limit, rectifier and protection control
//
// Notes on behaviour
// - each bit lasts half a millisecond
// - toggle modulation at every bit boundary
// - logic one adds a mid-bit transition
// - eleven-bit frame, data LSB first
// - start zero, stop one, odd parity
// - drive both modulation switches together
// - below 300 mA clamp at 400 mA
// - above 300 mA limit is current plus 50
// - release limit when packet finishes
// - mode select 0/1 disables communication limit
// - diode rectification during start-up
// - half-synchronous after undervoltage cleared
// - full-synchronous with hysteresis on load current
// - thermistor ratio compared to hot, cold
// - control pin low: overtemperature end packet
// - control pin high: unknown-reason end packet
// - die shutdown: regulator off, internal fault
// - resume only after temperature hysteresis
// - end packet header 0x02 then reason
`default_nettype none
module rx_comm_ctrl
	import rx_comm_pkg::*;
(
	// clock and reset
	input  wire logic            hclk,
	input  wire logic            hresetn,
	// ahb-lite slave
	input  wire logic            hsel,
	input  wire logic [AW-1:0]   haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire logic [31:0]     hwdata,
	input  wire logic            hready,
	output logic      [31:0]     hrdata,
	output logic                 hreadyout,
	output logic                 hresp,
	// analog comparator pins (asynchronous)
	input  wire logic            uvlo_ok_pin,
	input  wire logic            above_full_sync_pin,
	input  wire logic            below_half_return_pin,
	input  wire logic            die_hot_pin,
	input  wire logic            die_cool_pin,
	input  wire logic            ts_above_cold_pin,
	input  wire logic            ts_below_hot_pin,
	input  wire logic            mode_select_a,
	input  wire logic            mode_select_b,
	// output current measurement, mA
	input  wire logic [11:0]     iout_ma,
	// outputs
	output logic                 mod_switch_a,
	output logic                 mod_switch_b,
	output logic [11:0]          ilim_ma,
	output logic                 ilim_active,
	output logic [1:0]           rect_mode,
	output logic                 regulator_en,
	output logic                 ts_hot_flag,
	output logic                 ts_cold_flag
);
	// ----------------------------------------------------------------
	// synchronisers for pin inputs
	// ----------------------------------------------------------------
	localparam int unsigned NS = 9;
	logic [NS-1:0] pin_raw;
	logic [NS-1:0] sync1_q;
	logic [NS-1:0] sync2_q;
	assign pin_raw = {uvlo_ok_pin, above_full_sync_pin, below_half_return_pin,
		die_hot_pin, die_cool_pin, ts_above_cold_pin, ts_below_hot_pin,
		mode_select_a, mode_select_b};

	// two-flop chain per pin
	genvar g;
	generate
		for (g = 0; g < NS; g++) begin : gen_sync
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					sync1_q[g] <= 1'b0;
					sync2_q[g] <= 1'b0;
				end else begin
					sync1_q[g] <= pin_raw[g];
					sync2_q[g] <= sync1_q[g];
				end
			end
		end
	endgenerate

	analog_flags_t af;
	logic          ts_cold_s;
	logic          ts_hot_s;
	logic          msel_a_s;
	logic          msel_b_s;
	assign af.uvlo_ok           = sync2_q[8];
	assign af.above_full_sync   = sync2_q[7];
	assign af.below_half_return = sync2_q[6];
	assign af.die_hot           = sync2_q[5];
	assign af.die_cool          = sync2_q[4];
	assign ts_cold_s            = sync2_q[3];
	assign ts_hot_s             = sync2_q[2];
	assign msel_a_s             = sync2_q[1];
	assign msel_b_s             = sync2_q[0];

	// ----------------------------------------------------------------
	// bus address phase capture
	// ----------------------------------------------------------------
	logic          wr_pend_q;   // write data phase pending
	logic [AW-1:0] addr_q;      // captured address
	logic          ap_valid;
	assign ap_valid = hsel && hready && htrans[1];

	// register decode
	function automatic logic is_reg(input logic [AW-1:0] a, input logic [7:0] r);
		is_reg = (a == r);
	endfunction

	// address phase, zero wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			addr_q    <= '0;
		end else begin
			wr_pend_q <= ap_valid && hwrite;
			if (ap_valid) begin
				addr_q <= haddr;
			end
		end
	end

	// ----------------------------------------------------------------
	// software packet registers
	// ----------------------------------------------------------------
	logic [31:0] sw_data_q;  // up to four bytes, byte 0 first
	logic [2:0]  sw_len_q;   // byte count, 0 not sent, above 4 sent as 4
	logic        sw_go_q;    // request pending
	logic        sw_take;    // sequencer accepted request
	logic        sw_write;

	assign sw_write = wr_pend_q;

	// packet data and control
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sw_data_q <= '0;
			sw_len_q  <= '0;
			sw_go_q   <= 1'b0;
		end else begin
			if (sw_write && is_reg(addr_q, REG_DATA0)) begin
				sw_data_q <= hwdata;
			end
			if (sw_write && is_reg(addr_q, REG_CTRL) && hwdata[CTRL_GO]) begin
				sw_go_q  <= 1'b1;
				sw_len_q <= hwdata[CTRL_LEN +: 3];
			end else if (sw_take) begin
				sw_go_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// protection: host control pin and die temperature
	// ----------------------------------------------------------------
	logic       thermal_sd_q;  // latched thermal shutdown
	logic       host_sd_q;     // registered host shutdown, follows the control pin comparators
	logic       ept_req_q;     // end packet pending
	logic [7:0] ept_reason_q;
	logic       ept_take;

	// thermal shutdown with hysteresis release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			thermal_sd_q <= 1'b0;
		end else if (af.die_hot) begin
			thermal_sd_q <= 1'b1;
		end else if (af.die_cool) begin
			thermal_sd_q <= 1'b0;
		end
	end

	// host shutdown via control pin extremes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			host_sd_q <= 1'b0;
		end else begin
			host_sd_q <= ts_hot_s || ts_cold_s;
		end
	end

	// end packet request, set wins over take
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ept_req_q    <= 1'b0;
			ept_reason_q <= REASON_UNKNOWN;
		end else if (af.die_hot && !thermal_sd_q) begin
			ept_req_q    <= 1'b1;
			ept_reason_q <= REASON_FAULT;
		end else if (ts_hot_s && !host_sd_q) begin
			ept_req_q    <= 1'b1;
			ept_reason_q <= REASON_OVERTMP;
		end else if (ts_cold_s && !host_sd_q) begin
			ept_req_q    <= 1'b1;
			ept_reason_q <= REASON_UNKNOWN;
		end else if (ept_take) begin
			ept_req_q <= 1'b0;
		end
	end

	// comparator flags out, registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ts_hot_flag  <= 1'b0;
			ts_cold_flag <= 1'b0;
		end else begin
			ts_hot_flag  <= ts_hot_s;
			ts_cold_flag <= ts_cold_s;
		end
	end

	// regulator enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			regulator_en <= 1'b0;
		end else begin
			regulator_en <= af.uvlo_ok && !thermal_sd_q && !af.die_hot && !host_sd_q;
		end
	end

	// ----------------------------------------------------------------
	// packet sequencer
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {SQ_IDLE, SQ_LOAD, SQ_WAIT} seq_t;
	seq_t        seq_q;
	logic [31:0] pkt_q;     // remaining bytes, low byte next
	logic [2:0]  left_q;    // bytes left
	logic        ser_start;
	logic        ser_busy;
	logic        ser_done;
	logic        ser_level;
	logic        pkt_busy;

	assign ept_take  = (seq_q == SQ_IDLE) && ept_req_q;
	assign sw_take   = (seq_q == SQ_IDLE) && !ept_req_q && sw_go_q && (sw_len_q != 3'd0);
	assign ser_start = (seq_q == SQ_LOAD);
	assign pkt_busy  = (seq_q != SQ_IDLE);

	// byte sequencing, end packet ahead of software packets
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seq_q  <= SQ_IDLE;
			pkt_q  <= '0;
			left_q <= '0;
		end else begin
			unique case (seq_q)
				SQ_IDLE: begin
					if (ept_take) begin
						pkt_q  <= {16'h0000, ept_reason_q, HDR_END_POWER};
						left_q <= 3'd2;
						seq_q  <= SQ_LOAD;
					end else if (sw_take) begin
						pkt_q  <= sw_data_q;
						left_q <= (sw_len_q > 3'(MAX_BYTES)) ? 3'(MAX_BYTES) : sw_len_q;
						seq_q  <= SQ_LOAD;
					end
				end
				SQ_LOAD: begin
					seq_q <= SQ_WAIT;
				end
				SQ_WAIT: begin
					if (ser_done) begin
						pkt_q  <= {8'h00, pkt_q[31:8]};
						left_q <= left_q - 3'd1;
						seq_q  <= (left_q == 3'd1) ? SQ_IDLE : SQ_LOAD;
					end
				end
			endcase
		end
	end

	bit_serializer u_ser (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.start     (ser_start),
		.data      (pkt_q[7:0]),
		.busy      (ser_busy),
		.done      (ser_done),
		.mod_level (ser_level)
	);

	// both switches follow one level, open when idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mod_switch_a <= 1'b0;
			mod_switch_b <= 1'b0;
		end else begin
			mod_switch_a <= pkt_busy && ser_level;
			mod_switch_b <= pkt_busy && ser_level;
		end
	end

	// ----------------------------------------------------------------
	// communication current limit
	// ----------------------------------------------------------------
	logic limit_en;
	assign limit_en = pkt_busy && !(!msel_a_s && msel_b_s);

	// limit value while a packet is on the air
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ilim_ma     <= ILIM_NONE_MA;
			ilim_active <= 1'b0;
		end else if (!limit_en) begin
			ilim_ma     <= ILIM_NONE_MA;
			ilim_active <= 1'b0;
		end else if (!ilim_active) begin
			ilim_active <= 1'b1;
			if (iout_ma > ILIM_SWITCH_MA) begin
				ilim_ma <= iout_ma + ILIM_MARGIN_MA;
			end else begin
				ilim_ma <= ILIM_FIXED_MA;
			end
		end
	end

	// ----------------------------------------------------------------
	// rectifier mode
	// ----------------------------------------------------------------
	rect_mode_t rect_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rect_q <= RECT_DIODE;
		end else if (!af.uvlo_ok) begin
			rect_q <= RECT_DIODE;
		end else begin
			unique case (rect_q)
				RECT_DIODE: rect_q <= RECT_HALF;
				RECT_HALF: begin
					if (af.above_full_sync) begin
						rect_q <= RECT_FULL;
					end
				end
				RECT_FULL: begin
					if (af.below_half_return) begin
						rect_q <= RECT_HALF;
					end
				end
				default: rect_q <= RECT_DIODE;
			endcase
		end
	end

	// registered rectifier mode output
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rect_mode <= 2'(RECT_DIODE);
		end else begin
			rect_mode <= 2'(rect_q);
		end
	end

	// ----------------------------------------------------------------
	// bus read data and response
	// ----------------------------------------------------------------
	status_t st;
	assign st.busy        = pkt_busy;
	assign st.shutdown    = thermal_sd_q || host_sd_q;
	assign st.last_reason = ept_reason_q;

	// read data registered at the address phase, zero wait
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= '0;
		end else if (ap_valid && !hwrite) begin
			if (is_reg(haddr, REG_CTRL)) begin
				hrdata <= {25'd0, sw_len_q, 3'd0, sw_go_q};
			end else if (is_reg(haddr, REG_DATA0)) begin
				hrdata <= sw_data_q;
			end else if (is_reg(haddr, REG_STATUS)) begin
				hrdata <= {12'd0, ilim_active, 2'(rect_q), regulator_en, ts_hot_s,
					ts_cold_s, 4'd0, st} ;
			end else if (is_reg(haddr, REG_ILIM)) begin
				hrdata <= {20'd0, ilim_ma};
			end else begin
				hrdata <= '0;
			end
		end
	end

	// always ready, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	logic unused_ok;
	assign unused_ok = ^{hsize, ser_busy};
endmodule
`default_nettype wire

// *** sim/rx_comm_ctrl_props.sv ***
// checker: concurrent assertions on the communication controller ports
`default_nettype none
module rx_comm_ctrl_props
	import rx_comm_pkg::*;
(
	// clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// watched inputs
	input wire logic        uvlo_ok_pin,
	input wire logic        above_full_sync_pin,
	input wire logic        below_half_return_pin,
	input wire logic        die_hot_pin,
	input wire logic        ts_below_hot_pin,
	input wire logic        mode_select_a,
	input wire logic        mode_select_b,
	input wire logic [11:0] iout_ma,
	// watched outputs
	input wire logic        mod_switch_a,
	input wire logic        mod_switch_b,
	input wire logic [11:0] ilim_ma,
	input wire logic        ilim_active,
	input wire logic [1:0]  rect_mode,
	input wire logic        regulator_en,
	input wire logic        ts_hot_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ----------------------------------------------------------------
	// cycles since the modulation level last moved
	// ----------------------------------------------------------------
	int unsigned run_q;  // saturating run length
	logic        prev_q; // level one cycle back
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run_q  <= 2 * BIT_CYCLES;
			prev_q <= 1'b0;
		end else begin
			prev_q <= mod_switch_a;
			if (mod_switch_a != prev_q) run_q <= 0;
			else if (run_q < 2 * BIT_CYCLES) run_q <= run_q + 1;
		end
	end
	// ----------------------------------------------------------------
	// named sequences: inputs held past the synchronisers
	// ----------------------------------------------------------------
	sequence half_s; (uvlo_ok_pin && !above_full_sync_pin && below_half_return_pin)[*5]; endsequence
	sequence full_s; (uvlo_ok_pin && above_full_sync_pin)[*5]; endsequence
	sequence off_s; (!mode_select_a && mode_select_b)[*5]; endsequence
	a_switch_pair: assert property (mod_switch_a == mod_switch_b)
		else $error("modulation switches differ");
	a_idle_open: assert property (run_q > BIT_CYCLES + 4 |-> !prev_q)
		else $error("switch closed while idle");
	a_bit_spacing: assert property ($changed(mod_switch_a) |-> run_q >= HALF_CYCLES - 2)
		else $error("transitions closer than half a bit");
	a_ilim_fixed: assert property ($rose(ilim_active) && iout_ma < ILIM_SWITCH_MA
		&& $stable(iout_ma) |-> ilim_ma == ILIM_FIXED_MA) else $error("fixed limit wrong");
	a_ilim_track: assert property ($rose(ilim_active) && iout_ma > ILIM_SWITCH_MA
		&& $stable(iout_ma) |-> ilim_ma == iout_ma + ILIM_MARGIN_MA)
		else $error("tracking limit wrong");
	a_ilim_hold: assert property (ilim_active && $past(ilim_active) |-> $stable(ilim_ma))
		else $error("limit moved in packet");
	a_ilim_release: assert property (!ilim_active |-> ilim_ma == ILIM_NONE_MA)
		else $error("limit kept after packet");
	a_limit_off: assert property (off_s |-> !ilim_active)
		else $error("limit active in disabled mode");
	a_rect_half: assert property (half_s |-> rect_mode == RECT_HALF)
		else $error("rectifier not half");
	a_rect_full: assert property (full_s |-> rect_mode == RECT_FULL)
		else $error("rectifier not full");
	a_thermal_off: assert property (die_hot_pin[*5] |-> !regulator_en)
		else $error("regulator on while die hot");
	a_ts_hot: assert property (ts_below_hot_pin[*5] |-> ts_hot_flag)
		else $error("hot flag missing");
endmodule
bind rx_comm_ctrl rx_comm_ctrl_props u_props (.hclk(hclk), .hresetn(hresetn),
	.uvlo_ok_pin(uvlo_ok_pin), .above_full_sync_pin(above_full_sync_pin),
	.below_half_return_pin(below_half_return_pin), .die_hot_pin(die_hot_pin),
	.ts_below_hot_pin(ts_below_hot_pin), .mode_select_a(mode_select_a),
	.mode_select_b(mode_select_b), .iout_ma(iout_ma), .mod_switch_a(mod_switch_a),
	.mod_switch_b(mod_switch_b), .ilim_ma(ilim_ma), .ilim_active(ilim_active),
	.rect_mode(rect_mode), .regulator_en(regulator_en), .ts_hot_flag(ts_hot_flag));
`default_nettype wire

// *** sim/tx_demod_model.sv ***
// model: transmitter demodulator decoding bi-phase frames off the coil
`default_nettype none
module tx_demod_model
	import rx_comm_pkg::*;
(
	// clock and reset
	input wire logic         hclk,
	input wire logic         hresetn,
	// coil amplitude as the switches load it
	input wire logic         coil_level,
	// decoded frame, bit i is the i-th bit on air
	output logic [10:0]      bits_q,
	output int unsigned      n_q,
	output int unsigned      bad_q
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        prev_q;   // level one cycle back
	logic        active_q; // inside a frame
	logic        s1_q;     // quarter-bit sample
	logic        last_q;   // three-quarter sample of previous bit
	int unsigned t_q;      // cycle within the bit
	// ----------------------------------------------------------------
	// frame sync on first edge, then sample at quarter and three quarters
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{prev_q, active_q, s1_q, last_q} <= '0;
			t_q    <= 0;
			n_q    <= 0;
			bad_q  <= 0;
			bits_q <= '0;
		end else begin
			prev_q <= coil_level;
			if (!active_q) begin
				// a start edge opens the frame
				if (coil_level != prev_q) begin
					active_q <= 1'b1;
					t_q      <= 1;
					n_q      <= 0;
				end
			end else begin
				t_q <= (t_q == BIT_CYCLES - 1) ? 0 : t_q + 1;
				if (t_q == BIT_CYCLES / 4) begin
					s1_q <= coil_level;
					// boundary must have toggled the level
					if (n_q != 0 && coil_level == last_q) bad_q <= bad_q + 1;
				end
				if (t_q == 3 * BIT_CYCLES / 4) begin
					bits_q[n_q] <= s1_q ^ coil_level;
					last_q      <= coil_level;
					n_q         <= n_q + 1;
					if (n_q == FRAME_BITS - 1) active_q <= 1'b0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** sim/tb_wireless_rx_backscatter_comm.sv ***
// testbench: register, modulation, limit, rectifier and protection checks
`default_nettype none
module tb_wireless_rx_backscatter_comm;
	timeunit 1ns;
	timeprecision 1ps;
	import rx_comm_pkg::*;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        hclk, hresetn, hsel, hwrite, hresp, hreadyout;
	logic [7:0]  haddr, dat;
	logic [1:0]  htrans, rect_mode;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata, rd;
	logic        uvlo, above, below, d_hot, d_cool, ts_cold, ts_hot, msa, msb;
	logic [11:0] iout, ilim_ma;
	logic        sw_a, sw_b, ilim_on, reg_en, hot_f, cold_f;
	logic [10:0] rx_bits;
	int unsigned rx_n, rx_bad;
	int          bad_count, n_checks, seed, i;
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	rx_comm_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .uvlo_ok_pin(uvlo),
		.above_full_sync_pin(above), .below_half_return_pin(below), .die_hot_pin(d_hot),
		.die_cool_pin(d_cool), .ts_above_cold_pin(ts_cold), .ts_below_hot_pin(ts_hot),
		.mode_select_a(msa), .mode_select_b(msb), .iout_ma(iout), .mod_switch_a(sw_a),
		.mod_switch_b(sw_b), .ilim_ma(ilim_ma), .ilim_active(ilim_on), .rect_mode(rect_mode),
		.regulator_en(reg_en), .ts_hot_flag(hot_f), .ts_cold_flag(cold_f));
	tx_demod_model u_tx (.hclk(hclk), .hresetn(hresetn), .coil_level(sw_a),
		.bits_q(rx_bits), .n_q(rx_n), .bad_q(rx_bad));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// one single AHB-Lite transfer, read data left in rd
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1; haddr <= a; htrans <= 2'b10; hwrite <= wr;
		do begin @(posedge hclk); end while (hreadyout !== 1'b1);
		hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
		do begin @(posedge hclk); end while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rst();
		hresetn <= 1'b0;
		step(2);
		hresetn <= 1'b1;
		step(8);
	endtask
	task automatic wait_bits(input int unsigned n);
		int k;
		k = 0;
		while (rx_n < n && k < 300000) begin @(posedge hclk); k++; end
		chk("frame_wait", rx_n >= n, 1);
	endtask
	// expected frame: start, data lsb first, odd parity, stop
	function automatic logic [10:0] frame(input logic [7:0] d);
		return {1'b1, ~^d, d, 1'b0};
	endfunction
	task automatic summarize();
		if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// watchdog
	initial begin
		#8_000_000;
		bad_count++;
		summarize();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		seed = 13438; bad_count = 0; n_checks = 0;
		hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0;
		hsize = 3'b010; hwdata = '0; iout = '0; msa = 1'b0; msb = 1'b0;
		uvlo = 1'b0; above = 1'b0; below = 1'b1; d_hot = 1'b0; d_cool = 1'b1;
		ts_cold = 1'b0; ts_hot = 1'b0;
		step(2);
		hresetn <= 1'b1;
		step(8);
		chk("ilim", ilim_ma, ILIM_NONE_MA);
		bus(1'b0, REG_STATUS, '0);
		chk("status", rd[19:0], 20'h00000);
		bus(1'b0, 8'h10, '0);
		chk("unmapped", rd, '0);
		chk("hresp", hresp, 1'b0);
		chk("rect", rect_mode, RECT_DIODE);
		// rectifier steps: half, full, hysteresis hold, back to half
		uvlo <= 1'b1;
		for (i = 0; i < 4; i++) begin
			above <= (i == 1);
			below <= (i == 0 || i == 3);
			step(8);
			chk("rect", rect_mode, (i == 0 || i == 3) ? RECT_HALF : RECT_FULL);
		end
		// software packet at low current, aborted by reset mid-frame
		iout <= 12'(100 + {$random(seed)} % 150);
		dat = 8'($random(seed));
		bus(1'b1, REG_DATA0, {24'h0, dat});
		bus(1'b1, REG_CTRL, 32'h11);
		step(4);
		chk("ilim_on", ilim_on, 1);
		chk("ilim", ilim_ma, ILIM_FIXED_MA);
		wait_bits(2);
		chk("bits", rx_bits[1:0], {dat[0], 1'b0});
		rst();
		chk("idle", sw_a, 0);
		chk("ilim", ilim_ma, ILIM_NONE_MA);
		// limit disabled mode
		msb <= 1'b1;
		step(6);
		bus(1'b1, REG_CTRL, 32'h11);
		step(6);
		chk("ilim_on", ilim_on, 0);
		chk("ilim", ilim_ma, ILIM_NONE_MA);
		msb <= 1'b0;
		rst();
		// host pulls control pin low: overtemperature end packet
		iout <= 12'(301 + {$random(seed)} % 600);
		ts_hot <= 1'b1;
		step(8);
		chk("ilim", ilim_ma, iout + ILIM_MARGIN_MA);
		chk("hot", hot_f, 1);
		bus(1'b0, REG_STATUS, '0);
		chk("reason", rd[8:0], {1'b1, REASON_OVERTMP});
		wait_bits(11);
		chk("frame", rx_bits, frame(HDR_END_POWER));
		chk("edges", rx_bad, 0);
		ts_hot <= 1'b0;
		rst();
		// die overheat and recovery only after cooling
		d_hot <= 1'b1;
		d_cool <= 1'b0;
		step(8);
		chk("reg_en", reg_en, 0);
		bus(1'b0, REG_STATUS, '0);
		chk("reason", rd[7:0], REASON_FAULT);
		d_hot <= 1'b0;
		step(8);
		chk("reg_en", reg_en, 0);
		d_cool <= 1'b1;
		step(8);
		chk("reg_en", reg_en, 1);
		// host pulls control pin high: unknown-reason end packet
		ts_cold <= 1'b1;
		step(8);
		chk("cold", cold_f, 1);
		bus(1'b0, REG_STATUS, '0);
		chk("reason", rd[8:0], {1'b1, REASON_UNKNOWN});
		summarize();
	end
endmodule
`default_nettype wire
